// ==== pkg/srap_pkg.sv ====
package srap_pkg;
    // Link framing
    localparam int          SRAP_BYTE_W    = 8;
    localparam logic [2:0]  SRAP_LAST_BIT  = 3'h7;
    localparam logic [7:0]  SRAP_PTR_RST   = 8'h00;
    localparam logic [7:0]  SRAP_PTR_TOP   = 8'hFF;
    // Command codes, held as constants so an integrator can retarget them
    localparam logic [7:0]  SRAP_CMD_RESET = 8'h7A;
    localparam logic [7:0]  SRAP_CMD_SETP  = 8'h7D;
    localparam logic [7:0]  SRAP_CMD_WRITE = 8'h7E;
    localparam logic [7:0]  SRAP_CMD_READ  = 8'h7F;
    // Two-wire bus address, write FIFO depth and register space size
    localparam logic [6:0]  SRAP_I2C_ADDR  = 7'h28;
    localparam int          SRAP_FIFO_D    = 32;
    localparam int          SRAP_MEM_D     = 256;

    // Register write request carried into the write FIFO
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } srap_wr_s;

    typedef enum logic [1:0] {
        SRAP_SPI_CMD,
        SRAP_SPI_SETP,
        SRAP_SPI_WDATA,
        SRAP_SPI_RDATA
    } srap_spi_e;

    typedef enum logic [2:0] {
        SRAP_I2C_IDLE,
        SRAP_I2C_ADDR_PH,
        SRAP_I2C_REG,
        SRAP_I2C_WDATA,
        SRAP_I2C_RDATA,
        SRAP_I2C_ACK,
        SRAP_I2C_MACK,
        SRAP_I2C_SKIP
    } srap_i2c_e;
endpackage : srap_pkg

// ==== logic/srap_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module srap_sync #(
    parameter logic INIT = 1'b1
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic d,
    output var  logic q
);
    logic meta_r;

    // Two stages; only the second stage feeds logic
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_r <= INIT;
            q      <= INIT;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // srap_sync
`default_nettype wire

// ==== logic/srap_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module srap_fifo #(
    parameter int W = 16,
    parameter int D = 32
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;
    logic         full;
    logic         empty;

    // Extra pointer bit separates full from empty
    assign empty     = (wp_r == rp_r);
    assign full      = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_r[rp_r[AW-1:0]];

    // Storage
    always_ff @(posedge core_clk) begin
        if (in_valid && !full) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_ready && !empty) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule // srap_fifo
`default_nettype wire

// ==== logic/srap_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module srap_port
    import srap_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        spi_sel,
    input  wire logic        three_wire,
    input  wire logic        spi_clk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    input  wire logic        shared_serial_data_line_i,
    output logic             shared_serial_data_line_o,
    output logic             shared_serial_data_line_oe_n,
    input  wire logic        i2c_scl,
    input  wire logic        i2c_sda_i,
    output logic             i2c_sda_o,
    output logic             i2c_sda_oe_n,
    output logic             wr_valid,
    input  wire logic        wr_ready,
    output srap_wr_s         wr_req,
    output logic [7:0]       pointer,
    output logic             iface_reset
);
    // Synchronised pins
    logic sclk_s, cs_s, mosi_s, msio_s, scl_s, sda_s;

    srap_sync #(.INIT(1'b1)) u_sclk (.core_clk(core_clk), .rst_n(rst_n), .d(spi_clk),  .q(sclk_s));
    srap_sync #(.INIT(1'b1)) u_cs   (.core_clk(core_clk), .rst_n(rst_n), .d(spi_cs_n), .q(cs_s));
    srap_sync #(.INIT(1'b1)) u_mosi (.core_clk(core_clk), .rst_n(rst_n), .d(spi_mosi), .q(mosi_s));
    srap_sync #(.INIT(1'b1)) u_msio (.core_clk(core_clk), .rst_n(rst_n),
                                     .d(shared_serial_data_line_i), .q(msio_s));
    srap_sync #(.INIT(1'b1)) u_scl  (.core_clk(core_clk), .rst_n(rst_n), .d(i2c_scl),  .q(scl_s));
    srap_sync #(.INIT(1'b1)) u_sda  (.core_clk(core_clk), .rst_n(rst_n), .d(i2c_sda_i), .q(sda_s));

    // Register space
    logic [7:0] regs_r [SRAP_MEM_D];
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic       ptr_ld;
    logic       ptr_inc;

    // Edge detection on synchronised levels
    logic sclk_d_r, scl_d_r, sda_d_r;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            scl_d_r  <= scl_s;
            sda_d_r  <= sda_s;
        end
    end

    logic spi_act, s_rise, s_fall, s_din;
    assign spi_act = spi_sel && !cs_s;
    assign s_rise  = spi_act && sclk_s && !sclk_d_r;
    assign s_fall  = spi_act && !sclk_s && sclk_d_r;
    assign s_din   = three_wire ? msio_s : mosi_s;

    // ---------------- SPI shifter and decoder ----------------
    srap_spi_e  sst_r;
    logic [2:0] sbit_r;
    logic [6:0] sin_r;
    logic [7:0] sout_r;
    logic [7:0] last_r;
    logic       last_v_r;
    logic       sdrv_r;
    logic       sbit_out_r;
    logic       s_byte;
    logic [7:0] s_word;
    logic       s_rst2;
    logic       swr_fire;

    assign s_byte = s_rise && (sbit_r == SRAP_LAST_BIT);
    assign s_word = {sin_r, s_din};
    assign s_rst2 = s_byte && last_v_r && (last_r == SRAP_CMD_RESET)
                    && (s_word == SRAP_CMD_RESET);
    assign iface_reset = s_rst2;

    // Bit counter and input shift; deselect aborts partial byte
    // No timeout: a partial byte simply waits for more clocks
    always_ff @(posedge core_clk) begin
        if (!rst_n || !spi_act || s_rst2) begin
            sbit_r <= '0;
            sin_r  <= '0;
        end else if (s_rise) begin
            sbit_r <= sbit_r + 3'h1;
            sin_r  <= s_word[6:0];
        end
    end

    // Reset code tracker, looks at command and data bytes alike
    always_ff @(posedge core_clk) begin
        if (!rst_n || !spi_act || s_rst2) begin
            last_v_r <= 1'b0;
            last_r   <= '0;
        end else if (s_byte) begin
            last_v_r <= 1'b1;
            last_r   <= s_word;
        end
    end

    // Phase machine; chip select held low lets commands chain
    always_ff @(posedge core_clk) begin
        if (!rst_n || !spi_act || s_rst2) begin
            sst_r <= SRAP_SPI_CMD;
        end else if (s_byte) begin
            case (sst_r)
                SRAP_SPI_CMD: begin
                    case (s_word)
                        SRAP_CMD_SETP:  sst_r <= SRAP_SPI_SETP;
                        SRAP_CMD_WRITE: sst_r <= SRAP_SPI_WDATA;
                        SRAP_CMD_READ:  sst_r <= SRAP_SPI_RDATA;
                        default:        sst_r <= SRAP_SPI_CMD;
                    endcase
                end
                // Four-wire reads run on while clocked; three-wire hands the line back
                SRAP_SPI_RDATA: begin
                    sst_r <= three_wire ? SRAP_SPI_CMD : SRAP_SPI_RDATA;
                end
                default: sst_r <= SRAP_SPI_CMD;
            endcase
        end
    end

    // Write data byte goes to the FIFO; stall holds the pointer too
    assign swr_fire = s_byte && (sst_r == SRAP_SPI_WDATA) && !s_rst2;

    // Output shifter: falling edge presents MSB first, sampled on rise
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sout_r <= '1;
        end else if (s_byte && sst_r == SRAP_SPI_SETP) begin
            sout_r <= regs_r[s_word];
        end else if (s_byte && sst_r == SRAP_SPI_RDATA) begin
            sout_r <= regs_r[ptr_r + 8'h01];
        end else if (s_byte && sst_r == SRAP_SPI_CMD && s_word == SRAP_CMD_READ) begin
            sout_r <= regs_r[ptr_r];
        end else if (s_byte) begin
            sout_r <= regs_r[ptr_r];
        end else if (s_fall) begin
            sout_r <= {sout_r[6:0], 1'b1};
        end
    end

    // Driven bit moves only on falling clock, so a prefetch never
    // disturbs the line while the host may still be sampling it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sbit_out_r <= 1'b1;
        end else if (s_fall) begin
            sbit_out_r <= sout_r[7];
        end
    end

    // Shared line direction: device drives only in read data phase
    always_ff @(posedge core_clk) begin
        if (!rst_n || !spi_act) begin
            sdrv_r <= 1'b0;
        end else if (s_byte) begin
            // Release on the last rise so host and device never fight
            sdrv_r <= 1'b0;
        end else if (s_fall) begin
            sdrv_r <= three_wire && (sst_r == SRAP_SPI_RDATA);
        end
    end

    assign spi_miso                     = spi_act ? sbit_out_r : 1'b1;
    assign shared_serial_data_line_o    = sbit_out_r;
    assign shared_serial_data_line_oe_n = !sdrv_r;

    // ---------------- Two-wire slave ----------------
    srap_i2c_e  ist_r;
    srap_i2c_e  iret_r;
    logic [3:0] ibit_r;
    logic [7:0] ish_r;
    logic       irw_r;
    logic       i_sda_lo_r;
    logic       i_start, i_stop, i_rise, i_fall;
    logic       iwr_fire;
    logic       i_on;

    assign i_on    = !spi_sel;
    assign i_start = i_on && scl_s && scl_d_r && sda_d_r && !sda_s;
    assign i_stop  = i_on && scl_s && scl_d_r && !sda_d_r && sda_s;
    assign i_rise  = i_on && scl_s && !scl_d_r;
    assign i_fall  = i_on && !scl_s && scl_d_r;
    assign iwr_fire = i_rise && (ist_r == SRAP_I2C_WDATA) && (ibit_r == 4'h7);

    // Protocol state; stop returns to idle
    always_ff @(posedge core_clk) begin
        if (!rst_n || i_stop) begin
            ist_r  <= SRAP_I2C_IDLE;
            iret_r <= SRAP_I2C_IDLE;
            ibit_r <= '0;
            ish_r  <= '0;
            irw_r  <= 1'b0;
        end else if (i_start) begin
            ist_r  <= SRAP_I2C_ADDR_PH;
            ibit_r <= '0;
        end else if (i_rise) begin
            case (ist_r)
                SRAP_I2C_ADDR_PH, SRAP_I2C_REG, SRAP_I2C_WDATA: begin
                    ish_r  <= {ish_r[6:0], sda_s};
                    ibit_r <= ibit_r + 4'h1;
                    if (ibit_r == 4'h7) begin
                        ist_r <= SRAP_I2C_ACK;
                        if (ist_r == SRAP_I2C_ADDR_PH) begin
                            irw_r <= sda_s;
                            if (ish_r[6:0] != SRAP_I2C_ADDR) begin
                                ist_r <= SRAP_I2C_SKIP;
                            end
                            iret_r <= sda_s ? SRAP_I2C_RDATA : SRAP_I2C_REG;
                        end else begin
                            iret_r <= SRAP_I2C_WDATA;
                        end
                    end
                end
                SRAP_I2C_RDATA: begin
                    ibit_r <= ibit_r + 4'h1;
                    if (ibit_r == 4'h7) begin
                        ist_r <= SRAP_I2C_MACK;
                    end
                end
                SRAP_I2C_ACK: begin
                    ist_r  <= iret_r;
                    ibit_r <= '0;
                end
                SRAP_I2C_MACK: begin
                    ibit_r <= '0;
                    ist_r  <= sda_s ? SRAP_I2C_SKIP : SRAP_I2C_RDATA;
                end
                default: ist_r <= ist_r;
            endcase
        end
    end

    // Data line drive: ack low, read bits MSB first, changed on falling clock
    always_ff @(posedge core_clk) begin
        if (!rst_n || i_stop || i_start || !i_on) begin
            i_sda_lo_r <= 1'b0;
        end else if (i_fall) begin
            if (ist_r == SRAP_I2C_ACK) begin
                i_sda_lo_r <= 1'b1;
            end else if (ist_r == SRAP_I2C_RDATA) begin
                i_sda_lo_r <= !regs_r[ptr_r][3'h7 - ibit_r[2:0]];
            end else begin
                i_sda_lo_r <= 1'b0;
            end
        end
    end

    assign i2c_sda_o    = 1'b0;
    assign i2c_sda_oe_n = !i_sda_lo_r;

    // ---------------- Pointer and register space ----------------
    logic i_reg_ld, i_rd_done;
    assign i_reg_ld  = i_rise && (ist_r == SRAP_I2C_REG) && (ibit_r == 4'h7);
    assign i_rd_done = i_rise && (ist_r == SRAP_I2C_RDATA) && (ibit_r == 4'h7);

    logic     wr_pend_r;
    srap_wr_s wr_req_r;

    // Pending write waits for acceptance; link bytes come far slower
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
        end else if (swr_fire || iwr_fire) begin
            wr_pend_r <= 1'b1;
        end else if (wr_ready) begin
            wr_pend_r <= 1'b0;
        end
    end

    // Request captured at the byte's last rise, address is the old pointer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_req_r <= '0;
        end else if (swr_fire) begin
            wr_req_r <= '{addr: ptr_r, data: s_word};
        end else if (iwr_fire) begin
            wr_req_r <= '{addr: ptr_r, data: {ish_r[6:0], sda_s}};
        end
    end

    assign wr_valid = wr_pend_r;
    assign wr_req   = wr_req_r;

    // The byte completing the interface reset code never moves the pointer
    assign ptr_ld  = i_reg_ld || (s_byte && sst_r == SRAP_SPI_SETP && !s_rst2);
    assign ptr_inc = (wr_valid && wr_ready) || i_rd_done
                     || (s_byte && sst_r == SRAP_SPI_RDATA && !s_rst2);
    always_comb begin
        ptr_nxt = ptr_r;
        if (ptr_ld) begin
            ptr_nxt = i_reg_ld ? {ish_r[6:0], sda_s} : s_word;
        end else if (ptr_inc) begin
            ptr_nxt = ptr_r + 8'h01;
        end
    end

    // Pointer survives deselect and interface reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ptr_r <= SRAP_PTR_RST;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end
    assign pointer = ptr_r;

    // Writes drain from the FIFO into the register array
    logic     f_valid;
    srap_wr_s f_data;
    srap_fifo #(.W($bits(srap_wr_s)), .D(SRAP_FIFO_D)) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .in_valid (wr_valid && wr_ready),
        .in_ready (),
        .in_data  (wr_req),
        .out_valid(f_valid),
        .out_ready(1'b1),
        .out_data (f_data)
    );

    always_ff @(posedge core_clk) begin
        if (f_valid) begin
            regs_r[f_data.addr] <= f_data.data;
        end
    end
endmodule // srap_port
`default_nettype wire

// ==== tb/srap_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module srap_host_model (
    input  wire logic three_wire,
    output logic      spi_clk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso,
    input  wire logic sh_i,
    output logic      sh_d,
    output logic      sh_oe,
    output logic      i2c_scl,
    output logic      i2c_sda,
    input  wire logic i2c_wire
);
    // Both links rest high between frames
    initial begin
        spi_clk  = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
        sh_d     = 1'b1;
        sh_oe    = 1'b0;
        i2c_scl  = 1'b1;
        i2c_sda  = 1'b1;
    end
    // Odd offset keeps link edges away from core clock edges until a settle realigns them to a rising edge
    task automatic sel(input logic v);
        #43 spi_cs_n = v;
        #40;
    endtask
    // Shift on the falling edge, sample on the rising edge
    task automatic spi_bits(input logic [7:0] tx, input int n, input logic drv,
                            output logic [7:0] rx);
        rx = 8'hFF;
        for (int i = 7; i > 7 - n; i--) begin
            spi_clk  = 1'b0;
            spi_mosi = tx[i];
            sh_oe    = drv; // Line handed over for read data
            sh_d     = tx[i];
            #40 spi_clk = 1'b1;
            rx[i] = three_wire ? sh_i : spi_miso;
            #40;
        end
        sh_oe    = 1'b0;
        spi_mosi = 1'b1;
    endtask
    // Start or repeated start: data falls while clock high
    task automatic i2c_start;
        #20 i2c_sda = 1'b1;
        #40 i2c_scl = 1'b1;
        #40 i2c_sda = 1'b0;
        #40 i2c_scl = 1'b0;
    endtask
    // Stop: data rises while clock high
    task automatic i2c_stop;
        #20 i2c_sda = 1'b0;
        #40 i2c_scl = 1'b1;
        #40 i2c_sda = 1'b1;
        #40;
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #20 i2c_sda = tx[i];
            #20 i2c_scl = 1'b1;
            rx[i] = i2c_wire;
            #40 i2c_scl = 1'b0;
        end
    endtask
endmodule // srap_host_model
`default_nettype wire

// ==== tb/srap_port_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module srap_port_assertions (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       spi_sel,
    input wire logic       three_wire,
    input wire logic       spi_clk,
    input wire logic       spi_cs_n,
    input wire logic       spi_miso,
    input wire logic       shared_serial_data_line_oe_n,
    input wire logic       i2c_scl,
    input wire logic       i2c_sda_oe_n,
    input wire logic [7:0] pointer,
    input wire logic       iface_reset
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Deselected or four-wire port stays quiet; six cycles (four for two-wire) cover the pin synchroniser
    a_miso_idle_high: assert property (spi_cs_n [*6] |-> spi_miso)
        else $error("miso not idle high");
    a_shared_quiet: assert property (spi_cs_n [*6] |-> shared_serial_data_line_oe_n)
        else $error("shared line driven while deselected");
    a_four_wire_quiet: assert property (!three_wire [*6] |-> shared_serial_data_line_oe_n)
        else $error("shared line driven in four-wire mode");
    a_i2c_quiet_spi: assert property (spi_sel [*4] |-> i2c_sda_oe_n)
        else $error("two-wire data pulled in link mode");
    // Output bits change only while the link clock is low
    a_miso_fall_edge: assert property (!spi_cs_n [*6] ##1 $changed(spi_miso) |-> !spi_clk)
        else $error("miso changed while clock high");
    a_ack_scl_low: assert property ($fell(i2c_sda_oe_n) |-> !i2c_scl)
        else $error("two-wire data pulled while clock high");
    // Pointer survives deselect and interface reset
    a_ptr_hold_idle: assert property ((spi_sel && spi_cs_n) [*8] |-> $stable(pointer))
        else $error("pointer moved while deselected");
    a_rst_keeps_ptr: assert property (iface_reset |=> $stable(pointer))
        else $error("pointer changed by interface reset");
    a_rst_pulse_one: assert property (iface_reset |=> !iface_reset)
        else $error("interface reset longer than one cycle");
    c_iface_reset: cover property (iface_reset);
    c_shared_drive: cover property (!shared_serial_data_line_oe_n);
    c_i2c_ack: cover property (!i2c_sda_oe_n);
endmodule // srap_port_assertions
bind srap_port srap_port_assertions u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .spi_sel(spi_sel), .three_wire(three_wire),
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .shared_serial_data_line_oe_n(shared_serial_data_line_oe_n), .i2c_scl(i2c_scl),
    .i2c_sda_oe_n(i2c_sda_oe_n), .pointer(pointer), .iface_reset(iface_reset)
);
`default_nettype wire

// ==== tb/tb_serial_register_access_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_serial_register_access_port
    import srap_pkg::*;
();
    logic       core_clk = 1'b0;
    logic       rst_n, spi_sel, three_wire, wr_ready, wr_valid, iface_reset;
    logic       spi_clk, spi_cs_n, spi_mosi, spi_miso, i2c_scl, h_sda, sda_o, sda_oe_n;
    logic       sh_o, sh_oe_n, h_sh_d, h_sh_oe;
    wire        sh_i, sda_i;
    logic [7:0] pointer;
    srap_wr_s   wr_req, exp_w;
    srap_wr_s   exp_q[$];
    int         bad_count = 0, tests_run = 0, resets_seen = 0;

    always #5 core_clk = ~core_clk;
    // Undriven lines settle at the pull-up level
    assign sh_i  = !sh_oe_n ? sh_o : (h_sh_oe ? h_sh_d : 1'b1);
    assign sda_i = h_sda & (sda_oe_n | sda_o);

    srap_port dut (
        .core_clk(core_clk), .rst_n(rst_n), .spi_sel(spi_sel), .three_wire(three_wire),
        .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .shared_serial_data_line_i(sh_i), .shared_serial_data_line_o(sh_o),
        .shared_serial_data_line_oe_n(sh_oe_n), .i2c_scl(i2c_scl), .i2c_sda_i(sda_i),
        .i2c_sda_o(sda_o), .i2c_sda_oe_n(sda_oe_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_req(wr_req), .pointer(pointer), .iface_reset(iface_reset)
    );
    srap_host_model host (
        .three_wire(three_wire), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .sh_i(sh_i), .sh_d(h_sh_d), .sh_oe(h_sh_oe), .i2c_scl(i2c_scl),
        .i2c_sda(h_sda), .i2c_wire(sda_i)
    );

    // Random stalls on the write path
    always @(posedge core_clk) wr_ready <= ($urandom % 4) != 0;
    // Oldest note against each accepted write; negedge keeps samples settled
    always @(negedge core_clk) begin
        if (rst_n && wr_valid && wr_ready) begin
            exp_w = exp_q.size() ? exp_q.pop_front() : 'x;
            `CHK(wr_req, exp_w)
        end
        if (rst_n && iface_reset) resets_seen++;
    end

    task automatic settle;
        repeat (8) @(posedge core_clk);
    endtask
    // Bytes returned during set-pointer and write are not trusted
    task automatic cmd(input logic [7:0] c, input logic [7:0] d, output logic [7:0] rx);
        host.spi_bits(c, 8, 1'b1, rx);
        host.spi_bits(d, 8, c != SRAP_CMD_READ, rx);
    endtask
    task automatic i2c_tx(input logic [7:0] b);
        logic [8:0] r;
        host.i2c_byte({b, 1'b1}, r);
        `CHK(r[0], 1'b0)
    endtask
    task automatic give_verdict;
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] rx, d0, d1;
        logic [8:0] r9;
        rst_n      <= 1'b0;
        spi_sel    <= 1'b1;
        three_wire <= 1'b0;
        void'($urandom(20));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        settle();
        // Same sequence in four-wire, then three-wire mode
        for (int m = 0; m < 2; m++) begin
            three_wire <= m[0];
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            host.sel(1'b0);
            host.spi_bits(SRAP_CMD_SETP, 8, 1'b1, rx);
            #5000;
            host.spi_bits(8'hFE, 8, 1'b1, rx);
            settle();
            `CHK(pointer, 8'hFE)
            exp_q.push_back('{8'hFE, d0});
            cmd(SRAP_CMD_WRITE, d0, rx);
            exp_q.push_back('{8'hFF, d1});
            cmd(SRAP_CMD_WRITE, d1, rx);
            host.spi_bits(8'h55, 8, 1'b1, rx);
            settle();
            `CHK(pointer, 8'h00)
            cmd(SRAP_CMD_SETP, 8'hFE, rx);
            cmd(SRAP_CMD_READ, 8'hFF, rx);
            `CHK(rx, d0)
            if (m) begin
                cmd(SRAP_CMD_READ, 8'hFF, rx);
            end else begin
                host.spi_bits(8'hFF, 8, 1'b0, rx);
            end
            `CHK(rx, d1)
            // Deselect leaves the read phase; half a byte cut off, then double reset
            host.sel(1'b1);
            host.sel(1'b0);
            host.spi_bits(SRAP_CMD_SETP, 8, 1'b1, rx);
            host.spi_bits(8'h10, 4, 1'b1, rx);
            host.sel(1'b1);
            host.sel(1'b0);
            host.spi_bits(SRAP_CMD_RESET, 8, 1'b1, rx);
            host.spi_bits(SRAP_CMD_RESET, 8, 1'b1, rx);
            host.sel(1'b1);
            settle();
            `CHK(pointer, 8'h00)
            `CHK(resets_seen, m + 1)
        end
        // Two-wire block write across the top of the map, then read back
        spi_sel <= 1'b0;
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        settle();
        exp_q.push_back('{8'hFF, d0});
        exp_q.push_back('{8'h00, d1});
        host.i2c_start();
        i2c_tx({SRAP_I2C_ADDR, 1'b0});
        i2c_tx(8'hFF);
        i2c_tx(d0);
        i2c_tx(d1);
        host.i2c_stop();
        settle();
        `CHK(pointer, 8'h01)
        host.i2c_start();
        i2c_tx({SRAP_I2C_ADDR, 1'b0});
        i2c_tx(8'hFF);
        host.i2c_start();
        i2c_tx({SRAP_I2C_ADDR, 1'b1});
        host.i2c_byte({8'hFF, 1'b0}, r9);
        `CHK(r9[8:1], d0)
        host.i2c_byte({8'hFF, 1'b1}, r9);
        `CHK(r9[8:1], d1)
        host.i2c_stop();
        settle();
        `CHK(exp_q.size(), 0)
        give_verdict();
    end

    // Whole run needs well under 100 us
    initial begin
        #500000;
        bad_count++;
        give_verdict();
    end
endmodule // tb_serial_register_access_port
`default_nettype wire
